// ---- logic/pwm_sync_map.svh ----
`ifndef PWM_SYNC_MAP_SVH
`define PWM_SYNC_MAP_SVH

// register offsets on the plain register port
`define PRL_OFS    8'h00
`define PRH_OFS    8'h01
`define PHL_OFS    8'h02
`define PHH_OFS    8'h03
`define DCL_OFS    8'h04
`define DCH_OFS    8'h05
`define CTRL_OFS   8'h06
`define SYNC_OFS   8'h07
`define RISE_OFS   8'h08
`define FALL_OFS   8'h09
`define STAT_OFS   8'h0A
`define TBL_OFS    8'h0B
`define TBH_OFS    8'h0C

// field positions
`define CTRL_EN_BIT    0
`define CTRL_SKIP_BIT  1
`define SYNC_SEL_LSB   0
`define SYNC_SEL_MSB   1
`define SYNC_POFST_BIT 7

// reset values
`define BYTE_RST   8'h00
`define WORD_RST   16'h0000
`define ODD_RST    1'b1

`endif

// ---- logic/pwm_sync_pkg.sv ----
package pwm_sync_pkg;

    typedef struct packed {
        logic d;
        logic c;
        logic b;
        logic a;
    } bridge_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef enum logic [1:0] {
        SK_IDLE  = 2'b01,
        SK_ARMED = 2'b10
    } skip_state_t;

endpackage

// ---- logic/switch_mode_pwm_sync.sv ----
// Summary of operation
// - push-pull mode drives only A, B, C, D; no dead band, no steering.
// - A equals C and B equals D in push-pull mode.
// - odd periods: rise sets phases 0 and 2, fall clears them.
// - even periods: rise sets phases 1 and 3, fall clears them.
// - pulse skip: rise only when an enabled rise input is high at period.
// - qualified period: output A goes active at next synchronous rise.
// - pulse skip rise timing comes from the phase value pair.
// - pulse skip fall comes from duty match or enabled fall inputs, unqualified, clears A.
// - pulse skip drives output A only, no dead band, no steering.
// - master sync pulse makes a period event in each selecting slave.
// - sync source is chosen only among the other modules on this device.
// - a slave restarts its time base counter on sync, not own period.
// - slave reception enabled by slave source select bits.
// - phase offset set: sync from rise, period starts drive, 100% duty.
// - phase offset clear: sync from period event, late rise cuts duty.
// - slave events lag one clock for period source, two for rise source.
// - period bits 7..0 in period low byte, read/write, reset zero.
// - period bits 15..8 in period high byte, read/write, reset zero.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_sync_map.svh"

module switch_mode_pwm_sync
    import pwm_sync_pkg::*;
#(
    parameter int NUM_PEERS  = 1, // other modules on this device
    parameter int NUM_INPUTS = 4  // asynchronous event inputs
)(
    input  wire logic                  i_core_clk,  // switching clock
    input  wire logic                  i_reset,     // sync, active high
    input  wire bus_req_t              i_bus,       // register request
    output var  logic [7:0]            o_rdata,     // read data
    input  wire logic [NUM_PEERS-1:0]  i_peer_sync, // peer sync pulses
    input  wire logic [NUM_INPUTS-1:0] i_rise_in,   // async rise sources
    input  wire logic [NUM_INPUTS-1:0] i_fall_in,   // async fall sources
    output var  bridge_t               o_bridge,    // bridge outputs
    output var  logic                  o_sync_out   // sync to peers
);

    generate
        if (NUM_PEERS < 1 || NUM_PEERS > 3 || NUM_INPUTS < 1 || NUM_INPUTS > 8)
        begin : g_bad
            $error("unsupported peer or input count");
        end
    endgenerate

    // selector 0 means no source; k picks peer k-1
    function automatic logic pick_peer(input logic [1:0] sel,
                                       input logic [NUM_PEERS-1:0] v);
        logic r;
        r = 1'b0;
        for (int k = 0; k < NUM_PEERS; k++)
        begin
            if (sel == 2'(k + 1))
                r = v[k];
        end
        return r;
    endfunction

    logic [7:0]            prl_reg;
    logic [7:0]            prh_reg;
    logic [7:0]            phl_reg;
    logic [7:0]            phh_reg;
    logic [7:0]            dcl_reg;
    logic [7:0]            dch_reg;
    logic [7:0]            ctrl_reg;
    logic [7:0]            sync_reg;
    logic [NUM_INPUTS-1:0] rise_en_reg;
    logic [NUM_INPUTS-1:0] fall_en_reg;
    logic [15:0]           tb_reg;
    logic                  odd_reg;
    logic [3:0]            phase_reg;
    skip_state_t           skip_reg;
    logic                  rise_d_reg;
    logic [7:0]            rdata_reg;
    logic                  sync_out_reg;
    logic [NUM_INPUTS-1:0] rise_s1_reg;
    logic [NUM_INPUTS-1:0] rise_s2_reg;
    logic [NUM_INPUTS-1:0] fall_s1_reg;
    logic [NUM_INPUTS-1:0] fall_s2_reg;

    logic [15:0] period;
    logic [15:0] phase;
    logic [15:0] duty;
    logic        en;
    logic        skip;
    logic        pofst;
    logic [1:0]  src_sel;
    logic        slave;
    logic        per_evt;
    logic        rise_match;
    logic        fall_evt;
    logic        set_evt;
    logic        qual;
    logic        cur_odd;

    assign period  = {prh_reg, prl_reg};
    assign phase   = {phh_reg, phl_reg};
    assign duty    = {dch_reg, dcl_reg};
    assign en      = ctrl_reg[`CTRL_EN_BIT];
    assign skip    = ctrl_reg[`CTRL_SKIP_BIT];
    assign pofst   = sync_reg[`SYNC_POFST_BIT];
    assign src_sel = sync_reg[`SYNC_SEL_MSB:`SYNC_SEL_LSB];

    // own sync output is never a source for this module
    assign slave   = en && (src_sel != 2'b00);
    // a slave takes its period event from the chosen peer only
    assign per_evt = en && (slave ? pick_peer(src_sel, i_peer_sync)
                                  : (tb_reg == period));
    assign rise_match = en && (tb_reg == phase);
    // period event starts the drive when the sync leaves from the rise
    assign set_evt = pofst ? per_evt : rise_match;
    assign qual    = |(rise_s2_reg & rise_en_reg);
    assign fall_evt = en && ((tb_reg == duty)
                             || |(fall_s2_reg & fall_en_reg));
    // parity in force after this cycle's period event
    assign cur_odd = per_evt ? ~odd_reg : odd_reg;

    // two flops before any logic sees the asynchronous inputs
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            rise_s1_reg <= '0;
            rise_s2_reg <= '0;
            fall_s1_reg <= '0;
            fall_s2_reg <= '0;
        end
        else
        begin
            rise_s1_reg <= i_rise_in;
            rise_s2_reg <= rise_s1_reg;
            fall_s1_reg <= i_fall_in;
            fall_s2_reg <= fall_s1_reg;
        end
    end

    // register writes
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            prl_reg     <= `BYTE_RST;
            prh_reg     <= `BYTE_RST;
            phl_reg     <= `BYTE_RST;
            phh_reg     <= `BYTE_RST;
            dcl_reg     <= `BYTE_RST;
            dch_reg     <= `BYTE_RST;
            ctrl_reg    <= `BYTE_RST;
            sync_reg    <= `BYTE_RST;
            rise_en_reg <= '0;
            fall_en_reg <= '0;
        end
        else if (i_bus.wr)
        begin
            case (i_bus.addr)
                `PRL_OFS:  prl_reg     <= i_bus.wdata;
                `PRH_OFS:  prh_reg     <= i_bus.wdata;
                `PHL_OFS:  phl_reg     <= i_bus.wdata;
                `PHH_OFS:  phh_reg     <= i_bus.wdata;
                `DCL_OFS:  dcl_reg     <= i_bus.wdata;
                `DCH_OFS:  dch_reg     <= i_bus.wdata;
                `CTRL_OFS: ctrl_reg    <= {6'h00, i_bus.wdata[1:0]};
                `SYNC_OFS: sync_reg    <= {i_bus.wdata[7], 5'h00,
                                           i_bus.wdata[1:0]};
                `RISE_OFS: rise_en_reg <= i_bus.wdata[NUM_INPUTS-1:0];
                `FALL_OFS: fall_en_reg <= i_bus.wdata[NUM_INPUTS-1:0];
                default:   ;
            endcase
        end
    end

    // read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset || !i_bus.rd)
            rdata_reg <= 8'h00;
        else
        begin
            case (i_bus.addr)
                `PRL_OFS:  rdata_reg <= prl_reg;
                `PRH_OFS:  rdata_reg <= prh_reg;
                `PHL_OFS:  rdata_reg <= phl_reg;
                `PHH_OFS:  rdata_reg <= phh_reg;
                `DCL_OFS:  rdata_reg <= dcl_reg;
                `DCH_OFS:  rdata_reg <= dch_reg;
                `CTRL_OFS: rdata_reg <= ctrl_reg;
                `SYNC_OFS: rdata_reg <= sync_reg;
                `RISE_OFS: rdata_reg <= 8'(rise_en_reg);
                `FALL_OFS: rdata_reg <= 8'(fall_en_reg);
                `STAT_OFS: rdata_reg <= {2'b00, skip_reg == SK_ARMED,
                                         phase_reg, odd_reg};
                `TBL_OFS:  rdata_reg <= tb_reg[7:0];
                `TBH_OFS:  rdata_reg <= tb_reg[15:8];
                default:   rdata_reg <= 8'h00;
            endcase
        end
    end

    // time base; a slave wraps only on the peer sync
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset || !en)
            tb_reg <= `WORD_RST;
        else if (per_evt)
            tb_reg <= `WORD_RST;
        else
            tb_reg <= tb_reg + 16'h0001;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset || !en)
            odd_reg <= `ODD_RST;
        else if (per_evt)
            odd_reg <= ~odd_reg;
    end

    // pulse skip qualifier: armed at a qualified period, spent at next rise
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset || !en || !skip)
            skip_reg <= SK_IDLE;
        else
        begin
            case (skip_reg)
                SK_IDLE:
                    if (per_evt && qual)
                        skip_reg <= SK_ARMED;
                SK_ARMED:
                    if (set_evt)
                        skip_reg <= SK_IDLE;
                default:
                    skip_reg <= SK_IDLE;
            endcase
        end
    end

    // drive phases; a fall in the same cycle as a rise wins (zero duty)
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset || !en)
            phase_reg <= 4'h0;
        else if (skip)
        begin
            phase_reg[3:1] <= 3'b000;
            if (fall_evt)
                phase_reg[0] <= 1'b0;
            else if (skip_reg == SK_ARMED && set_evt)
                phase_reg[0] <= 1'b1;
        end
        else if (cur_odd)
        begin
            // the other pair is dropped so the bridge never shoots through
            // fall is tested first so a duty equal to phase gives no pulse
            if (fall_evt)
                phase_reg <= phase_reg & 4'b1010;
            else if (set_evt)
                phase_reg <= 4'b0101;
        end
        else
        begin
            if (fall_evt)
                phase_reg <= phase_reg & 4'b0101;
            else if (set_evt)
                phase_reg <= 4'b1010;
        end
    end

    // the rise source takes one extra stage, giving the two-clock skid
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            rise_d_reg <= 1'b0;
        else
            rise_d_reg <= rise_match;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset || !en)
            sync_out_reg <= 1'b0;
        else
            sync_out_reg <= pofst ? rise_d_reg : per_evt;
    end

    // A and C sit on phase flops 0 and 2, B and D on 1 and 3; push-pull sets and clears each pair together
    assign o_bridge.a  = phase_reg[0];
    assign o_bridge.b  = phase_reg[1];
    assign o_bridge.c  = phase_reg[2];
    assign o_bridge.d  = phase_reg[3];
    assign o_rdata     = rdata_reg;
    assign o_sync_out  = sync_out_reg;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    sequence period_src_s;
        per_evt && !pofst;
    endsequence

    sequence rise_src_s;
        rise_match && pofst ##1 pofst;
    endsequence

    sequence qualified_s;
        en && skip && !slave && per_evt && qual && skip_reg == SK_IDLE;
    endsequence

    // the rise that spends an armed qualifier
    sequence armed_rise_s;
        skip_reg == SK_ARMED && set_evt && !fall_evt && skip && en;
    endsequence

    // pulse skip drives a alone, so the pairing only holds in push-pull
    pair_equal_a: assert property (
        !skip |-> o_bridge.a == o_bridge.c && o_bridge.b == o_bridge.d)
        else $error("bridge pairs differ");

    skip_only_a_a: assert property (
        skip |=> !o_bridge.b && !o_bridge.d)
        else $error("pulse skip drove b or d");

    odd_rise_a: assert property (
        !skip && set_evt && cur_odd && !fall_evt |=> o_bridge.a && !o_bridge.b)
        else $error("odd rise wrong pair");

    even_rise_a: assert property (
        !skip && set_evt && !cur_odd && !fall_evt |=> o_bridge.b && !o_bridge.a)
        else $error("even rise wrong pair");

    odd_fall_a: assert property (
        !skip && fall_evt && cur_odd |=> !o_bridge.a && !o_bridge.c)
        else $error("odd fall left pair active");

    period_wrap_a: assert property (
        per_evt && en |=> tb_reg == 16'h0000 && odd_reg != $past(odd_reg))
        else $error("period event did not wrap");

    slave_reset_a: assert property (
        slave && !per_evt && $past(en) |=> tb_reg != 16'h0000 || $past(per_evt))
        else $error("slave restarted without sync");

    period_lag_a: assert property (
        period_src_s ##1 !pofst && en |-> o_sync_out)
        else $error("period sync lag wrong");

    rise_lag_a: assert property (
        rise_src_s ##1 pofst && en |-> o_sync_out)
        else $error("rise sync lag wrong");

    skip_unqual_a: assert property (
        en && skip && skip_reg == SK_IDLE && !o_bridge.a && !qual
        |=> !o_bridge.a)
        else $error("unqualified pulse");

    skip_arm_a: assert property (
        qualified_s |=> skip_reg == SK_ARMED)
        else $error("qualified period not armed");

    skip_pulse_a: assert property (
        armed_rise_s |=> o_bridge.a)
        else $error("qualified pulse missing");

    period_reset_a: assert property (
        $past(i_reset) |-> prl_reg == 8'h00 && prh_reg == 8'h00)
        else $error("period not cleared");

endmodule
`default_nettype wire

// ---- testbench/peer_sync_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// stands in for a peer modulator acting as sync master on the same device
module peer_sync_model #(
    parameter int GAP = 20 // clocks between sync pulses
)(
    input  wire logic i_core_clk, // shared switching clock
    input  wire logic i_reset,    // sync reset, active high
    input  wire logic i_run,      // peer enabled
    output var  logic o_sync      // one-clock sync pulse
);
    int cnt_reg;

    // a stopped peer sends nothing, so a stale pulse never leaks out
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset || !i_run)
        begin
            cnt_reg <= 0;
            o_sync  <= 1'b0;
        end
        else
        begin
            cnt_reg <= (cnt_reg == GAP - 1) ? 0 : cnt_reg + 1;
            o_sync  <= (cnt_reg == GAP - 1);
        end
    end
endmodule
`default_nettype wire

// ---- testbench/switch_mode_pwm_sync_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pwm_sync_map.svh"
module switch_mode_pwm_sync_tb
    import pwm_sync_pkg::*;
;
    logic       clk;
    logic       rst;
    bus_req_t   i_bus;
    logic [7:0] rdata;
    logic       peer_sync;
    logic       peer_run;
    logic [3:0] rise_in;
    logic [3:0] fall_in;
    bridge_t    bridge;
    logic       sync_out;
    int miscompares, checks_done, cyc, na, nb, ncd, eq_err, ovl;
    int a_gap, a_len, b_len, s_gap, run_a, run_b, last_a, last_s;
    logic prev_a, prev_b;

    switch_mode_pwm_sync dut_u (.i_core_clk(clk), .i_reset(rst), .i_bus(i_bus), .o_rdata(rdata),
        .i_peer_sync(peer_sync), .i_rise_in(rise_in), .i_fall_in(fall_in), .o_bridge(bridge),
        .o_sync_out(sync_out));
    peer_sync_model #(.GAP(20)) peer_u (.i_core_clk(clk), .i_reset(rst), .i_run(peer_run), .o_sync(peer_sync));

    always #4 clk = ~clk;

    task automatic wrap_up();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_cnt(input int got, input int exp, input string what);
        checks_done++;
        if (got != exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // outputs are registered, so they are settled by the falling edge
    always @(negedge clk)
    begin
        cyc++;
        na += bridge.a;
        nb += bridge.b;
        ncd += bridge.c + bridge.d;
        if (bridge.a !== bridge.c || bridge.b !== bridge.d) eq_err++;
        if (bridge.a && bridge.b) ovl++;
        if (bridge.a && !prev_a)
        begin
            if (last_a >= 0) a_gap = cyc - last_a;
            last_a = cyc;
        end
        // a run that just ended keeps its length before its counter clears
        if (!bridge.a && prev_a) a_len = run_a;
        if (!bridge.b && prev_b) b_len = run_b;
        run_a = bridge.a ? run_a + 1 : 0;
        run_b = bridge.b ? run_b + 1 : 0;
        if (sync_out)
        begin
            if (last_s >= 0) s_gap = cyc - last_s;
            last_s = cyc;
        end
        prev_a = bridge.a;
        prev_b = bridge.b;
        if (cyc > 30000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic clr_mon();
        {na, nb, ncd, eq_err, ovl, a_gap, a_len, b_len, s_gap} = '0;
        last_a = -1;
        last_s = -1;
    endtask

    task automatic bus_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        i_bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        i_bus <= '0;
    endtask

    task automatic bus_rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk);
        i_bus <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        i_bus <= '0;
        @(negedge clk);
        cmp_byte(rdata, exp, "read data");
    endtask

    task automatic watch(input int n);
        clr_mon();
        repeat (n) @(posedge clk);
    endtask

    task automatic t_regs();
        bus_rd(`PRL_OFS, 8'h00);
        bus_rd(`PRH_OFS, 8'h00);
        bus_wr(`PRL_OFS, 8'hA5);
        bus_wr(`PRH_OFS, 8'h5A);
        bus_wr(8'h0F, 8'hFF);
        bus_rd(`PRL_OFS, 8'hA5);
        bus_rd(`PRH_OFS, 8'h5A);
        bus_rd(8'h0F, 8'h00);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus_rd(`PRL_OFS, 8'h00);
        bus_rd(`PRH_OFS, 8'h00);
    endtask

    task automatic t_push_pull();
        bus_wr(`PRL_OFS, 8'h07);
        bus_wr(`PHL_OFS, 8'h01);
        bus_wr(`DCL_OFS, 8'h04);
        bus_wr(`CTRL_OFS, 8'h01);
        watch(80);
        cmp_cnt(a_gap, 16, "pair period");
        cmp_cnt(a_len, 3, "a width");
        cmp_cnt(b_len, 3, "b width");
        cmp_cnt(ovl, 0, "pair overlap");
        cmp_cnt(eq_err, 0, "a/c b/d mismatch");
        cmp_cnt(s_gap, 8, "sync spacing");
        bus_wr(`SYNC_OFS, 8'h80);
        watch(80);
        cmp_cnt(a_len, 5, "offset a width");
        cmp_cnt(s_gap, 8, "offset sync spacing");
        bus_wr(`SYNC_OFS, 8'h00);
        bus_wr(`CTRL_OFS, 8'h00);
    endtask

    task automatic t_slave();
        bus_wr(`PRL_OFS, 8'hFF);
        bus_wr(`SYNC_OFS, 8'h01);
        bus_wr(`DCL_OFS, 8'h03);
        bus_wr(`CTRL_OFS, 8'h01);
        peer_run <= 1'b1;
        watch(200);
        cmp_cnt(a_gap, 40, "slave pair period");
        cmp_cnt(a_len, 2, "trimmed width");
        cmp_cnt(s_gap, 20, "slave period events");
        bus_wr(`SYNC_OFS, 8'h00);
        watch(1300);
        cmp_cnt(a_gap, 512, "unselected period");
        peer_run <= 1'b0;
        bus_wr(`CTRL_OFS, 8'h00);
        bus_wr(`DCL_OFS, 8'h04);
    endtask

    task automatic t_skip();
        bus_wr(`PRL_OFS, 8'h07);
        bus_wr(`RISE_OFS, 8'h01);
        bus_wr(`FALL_OFS, 8'h00);
        bus_wr(`CTRL_OFS, 8'h03);
        watch(64);
        cmp_cnt(na, 0, "unqualified pulses");
        rise_in <= 4'h1;
        watch(64);
        cmp_cnt(a_gap, 8, "qualified spacing");
        cmp_cnt(a_len, 3, "pulse width");
        cmp_cnt(nb + ncd, 0, "other outputs");
        bus_wr(`PHL_OFS, 8'h02);
        watch(64);
        cmp_cnt(a_len, 2, "pulse width new phase");
        bus_wr(`FALL_OFS, 8'h01);
        fall_in <= 4'h1;
        watch(4);
        watch(64);
        cmp_cnt(na, 0, "fall input held");
    endtask

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        i_bus = '0;
        rise_in = 4'h0;
        fall_in = 4'h0;
        peer_run = 1'b0;
        {miscompares, checks_done, cyc, run_a, run_b} = '0;
        {prev_a, prev_b} = 2'b00;
        clr_mon();
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_push_pull();
        t_slave();
        t_skip();
        wrap_up();
    end
endmodule
`default_nettype wire
